// [hdl/wbc_pkg.sv]
`default_nettype none

package wbc_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [6:0] ADDR_HW   = 7'h02;
   localparam logic [6:0] ADDR_WD   = 7'h03;
   localparam logic [6:0] ADDR_BUS  = 7'h04;
   localparam logic [6:0] ADDR_PEAK = 7'h05;
   localparam logic [6:0] ADDR_WK   = 7'h07;

   // ****************************************
   // Reset values and writable masks
   // ****************************************
   localparam logic [7:0] HW_RST       = 8'h00;
   localparam logic [7:0] HW_WMASK     = 8'hfb;
   localparam logic [7:0] HW_SOFT_KEEP = 8'hc9;
   localparam logic [7:0] WD_RST       = 8'h14;
   localparam logic [7:0] WD_WMASK     = 8'hf7;
   localparam logic [7:0] WD_RS_KEEP   = 8'hb0;
   localparam logic [7:0] WD_RS_SET    = 8'h04;
   localparam logic [7:0] BUS_RST      = 8'h20;
   localparam logic [7:0] BUS_WMASK    = 8'hfb;
   localparam logic [7:0] BUS_UP_KEEP  = 8'he0;
   localparam logic [4:0] BUS_FS_LOW   = 5'h09;
   localparam logic [7:0] PEAK_RST     = 8'h00;
   localparam logic [7:0] PEAK_WMASK   = 8'h20;
   localparam logic [7:0] WK_RST       = 8'h07;
   localparam logic [7:0] WK_WMASK     = 8'ha7;
   localparam logic [7:0] WK_FS_KEEP   = 8'ha0;
   localparam logic [7:0] WK_FS_SET    = 8'h07;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int FAIL_OUT_SW_ENABLE_BIT     = 5;
   localparam int WD_STOP_BIT   = 6;
   localparam int WDOG_WINDOW_SELECT_BIT    = 5;
   localparam int WD_WAKE_BIT   = 4;
   localparam int WD_RSV_BIT    = 3;
   localparam int LIN_FLASH_BIT = 7;
   localparam int LIN_LOW_SLOPE_BIT   = 6;
   localparam int LIN_TO_BIT    = 5;
   localparam int BUS_RSV_BIT   = 2;
   localparam int PEAK_BIT      = 5;
   localparam int LIN_XCVRS     = 2;
   localparam int FRAME_BITS    = 16;

   // ****************************************
   // Watchdog periods in ms
   // ****************************************
   localparam logic [9:0] WD_P0_MS = 10'd10;
   localparam logic [9:0] WD_P1_MS = 10'd20;
   localparam logic [9:0] WD_P2_MS = 10'd50;
   localparam logic [9:0] WD_P3_MS = 10'd100;
   localparam logic [9:0] WD_P4_MS = 10'd200;
   localparam logic [9:0] WD_P5_MS = 10'd500;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
   } wbc_mode_t;

   typedef struct packed {
      logic [7:0] data;
      logic       wr;
      logic [6:0] addr;
   } wbc_frame_t;

   typedef struct packed {
      logic       off_in_stop;
      logic       window_sel;
      logic       period_valid;
      logic [9:0] period_ms;
   } wbc_wdog_cfg_t;

endpackage

`default_nettype wire

// [hdl/wbc_spi.sv]
`timescale 1ns/1ps
`default_nettype none

module wbc_spi (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               ce,
   // Serial pins
   input  wire logic               chip_select_n,
   input  wire logic               sclk,
   input  wire logic               sdi,
   output logic                    sdo,
   output logic                    sdo_oe,
   // Frame side
   input  wire logic [15:0]        tx_word,
   output wbc_pkg::wbc_frame_t     frame,
   output logic                    frame_valid
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] csn_q;
   logic [2:0] sck_q;
   logic [1:0] sdi_q;
   logic [15:0] rx_q;
   logic [15:0] tx_q;
   logic [4:0]  cnt_q;
   logic        sdo_q;
   logic        valid_q;
   wbc_pkg::wbc_frame_t frame_q;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         csn_q <= 3'h7;
         sck_q <= 3'h0;
         sdi_q <= 2'h0;
      end
      else if (ce)
      begin
         csn_q <= {csn_q[1:0], chip_select_n};
         sck_q <= {sck_q[1:0], sclk};
         sdi_q <= {sdi_q[0], sdi};
      end
   end

   // ****************************************
   // Shifting, LSB first
   // ****************************************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rx_q    <= 16'h0000;
         tx_q    <= 16'h0000;
         cnt_q   <= 5'h00;
         sdo_q   <= 1'b0;
         valid_q <= 1'b0;
         frame_q <= '0;
      end
      else if (ce)
      begin
         valid_q <= 1'b0;
         if (csn_q[2] && !csn_q[1])
         begin
            cnt_q <= 5'h00;
            tx_q  <= tx_word >> 1;
            sdo_q <= tx_word[0];
         end
         else if (!csn_q[1] && !sck_q[2] && sck_q[1])
         begin
            rx_q <= {sdi_q[1], rx_q[15:1]};
            if (cnt_q != 5'h1f)
               cnt_q <= cnt_q + 5'h01;
         end
         else if (!csn_q[1] && sck_q[2] && !sck_q[1])
         begin
            sdo_q <= tx_q[0];
            tx_q  <= tx_q >> 1;
         end
         // Only whole frames commit; short or long ones are dropped
         else if (!csn_q[2] && csn_q[1])
         begin
            valid_q <= (cnt_q == 5'(wbc_pkg::FRAME_BITS));
            frame_q <= rx_q;
         end
      end
   end

   assign sdo         = sdo_q;
   assign sdo_oe      = !csn_q[2];
   assign frame       = frame_q;
   assign frame_valid = valid_q;

endmodule // wbc_spi

`default_nettype wire

// [hdl/wbc_regs.sv]
// Operation
// - Failure flag keeps failure outputs on
// - Restart clears software enable, outputs off
// - Soft reset keeps aux regulator bits
// - Stop-disable bit turns watchdog off in stop
// - Bit five selects window or time-out
// - Bus wake in stop starts watchdog
// - Period codes select 10 to 500 ms
// - Watchdog register reset and restart values
// - Bit seven bypasses LIN slope control
// - Bit six selects LIN low slope
// - Bit five enables LIN transmit time-out
// - LIN mode field selects transceiver state
// - LIN options apply at chip-select rise, all
// - Fail-safe loads bus and wake values
// - Bus register reset and restart values
// - Peak bit selects regulator current threshold
// - Peak bit write ignored silently in stop
// - Reserved bits ignore writes, read zero
// - Software enable drives failure outputs
`timescale 1ns/1ps
`default_nettype none

module wbc_regs (
   // Clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst,
   input  wire logic                        ce,
   // Serial pins
   input  wire logic                        chip_select_n,
   input  wire logic                        sclk,
   input  wire logic                        sdi,
   output logic                             sdo,
   output logic                             sdo_oe,
   // Device state and events
   input  wire wbc_pkg::wbc_mode_t          sbc_mode,
   input  wire logic                        soft_reset_req,
   input  wire logic                        restart_entry,
   input  wire logic [3:0]                  restart_bus_modes,
   input  wire logic                        failsafe_entry,
   input  wire logic                        failure_flag,
   input  wire logic                        bus_wake_in_stop,
   // Watchdog controls
   output wbc_pkg::wbc_wdog_cfg_t           wdog_cfg,
   output logic                             wdog_bus_wake_start,
   // Transceiver controls
   output logic [wbc_pkg::LIN_XCVRS-1:0]    lin_slope_bypass,
   output logic [wbc_pkg::LIN_XCVRS-1:0]    lin_low_slope,
   output logic [wbc_pkg::LIN_XCVRS-1:0]    lin_tx_timeout_en,
   output logic [1:0]                       lin_mode_field,
   output logic [1:0]                       can_mode_field,
   // Supply and failure controls
   output logic                             peak_current_thresh_sel,
   output logic                             aux_reg_voltage_cfg,
   output logic                             aux_reg_load_share,
   output logic                             failure_outputs
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] merge(input logic [7:0] q, input logic [7:0] d,
                                         input logic [7:0] m);
      merge = (q & ~m) | (d & m);
   endfunction

   function automatic logic [9:0] period_ms(input logic [2:0] code);
      case (code)
         3'h0: period_ms = wbc_pkg::WD_P0_MS;
         3'h1: period_ms = wbc_pkg::WD_P1_MS;
         3'h2: period_ms = wbc_pkg::WD_P2_MS;
         3'h3: period_ms = wbc_pkg::WD_P3_MS;
         3'h4: period_ms = wbc_pkg::WD_P4_MS;
         3'h5: period_ms = wbc_pkg::WD_P5_MS;
         default: period_ms = 10'h000;
      endcase
   endfunction

   function automatic logic hit(input wbc_pkg::wbc_frame_t f, input logic [6:0] a);
      hit = f.wr && (f.addr == a);
   endfunction

   // ****************************************
   // Serial front end
   // ****************************************
   wbc_pkg::wbc_frame_t frame;
   logic                frame_valid;
   logic [7:0]          hw_q;
   logic [7:0]          wd_q;
   logic [7:0]          bus_q;
   logic [7:0]          peak_q;
   logic [7:0]          wk_q;
   logic [7:0]          rd_q;
   logic                fo_q;
   logic                wake_q;
   logic                wr_ok;
   logic                peak_open;

   wbc_spi u_spi (
      .clock         (clock),
      .rst           (rst),
      .ce            (ce),
      .chip_select_n (chip_select_n),
      .sclk          (sclk),
      .sdi           (sdi),
      .sdo           (sdo),
      .sdo_oe        (sdo_oe),
      .tx_word       ({rd_q, 8'h00}),
      .frame         (frame),
      .frame_valid   (frame_valid)
   );

   // Hardware events outrank a write in the same cycle
   assign wr_ok     = frame_valid && !soft_reset_req && !restart_entry && !failsafe_entry;
   assign peak_open = (sbc_mode == wbc_pkg::MODE_INIT) || (sbc_mode == wbc_pkg::MODE_NORMAL);

   // ****************************************
   // Read-back of the addressed register
   // ****************************************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rd_q <= 8'h00;
      else if (ce && frame_valid)
      begin
         case (frame.addr)
            wbc_pkg::ADDR_HW:   rd_q <= hw_q;
            wbc_pkg::ADDR_WD:   rd_q <= wd_q;
            wbc_pkg::ADDR_BUS:  rd_q <= bus_q;
            wbc_pkg::ADDR_PEAK: rd_q <= peak_q;
            wbc_pkg::ADDR_WK:   rd_q <= wk_q;
            default:            rd_q <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Hardware control register
   // ****************************************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         hw_q <= wbc_pkg::HW_RST;
      else if (ce)
      begin
         if (soft_reset_req)
            hw_q <= hw_q & wbc_pkg::HW_SOFT_KEEP;
         else if (restart_entry)
            hw_q[wbc_pkg::FAIL_OUT_SW_ENABLE_BIT] <= 1'b0;
         else if (wr_ok && hit(frame, wbc_pkg::ADDR_HW))
            hw_q <= merge(hw_q, frame.data, wbc_pkg::HW_WMASK);
      end
   end

   // ****************************************
   // Watchdog control register
   // ****************************************
   // Parity of the written byte is the host's duty; the byte is stored as given except reserved bit 3
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wd_q <= wbc_pkg::WD_RST;
      else if (ce)
      begin
         if (soft_reset_req)
            wd_q <= wbc_pkg::WD_RST;
         else if (restart_entry)
            wd_q <= (wd_q & wbc_pkg::WD_RS_KEEP) | wbc_pkg::WD_RS_SET;
         else if (wr_ok && hit(frame, wbc_pkg::ADDR_WD))
            wd_q <= merge(wd_q, frame.data, wbc_pkg::WD_WMASK);
      end
   end

   // ****************************************
   // Bus transceiver control register
   // ****************************************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         bus_q <= wbc_pkg::BUS_RST;
      else if (ce)
      begin
         if (soft_reset_req)
            bus_q <= wbc_pkg::BUS_RST;
         else if (failsafe_entry)
            bus_q <= {bus_q[7:5], wbc_pkg::BUS_FS_LOW};
         else if (restart_entry)
            bus_q <= (bus_q & wbc_pkg::BUS_UP_KEEP) |
                     {3'h0, restart_bus_modes[3:2], 1'b0, restart_bus_modes[1:0]};
         else if (wr_ok && hit(frame, wbc_pkg::ADDR_BUS))
            bus_q <= merge(bus_q, frame.data, wbc_pkg::BUS_WMASK);
      end
   end

   // ****************************************
   // Peak threshold and external wake
   // ****************************************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         peak_q <= wbc_pkg::PEAK_RST;
      else if (ce)
      begin
         if (soft_reset_req)
            peak_q <= wbc_pkg::PEAK_RST;
         // Stop-mode writes drop without any error report
         else if (wr_ok && hit(frame, wbc_pkg::ADDR_PEAK) && peak_open)
            peak_q <= merge(peak_q, frame.data, wbc_pkg::PEAK_WMASK);
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         wk_q <= wbc_pkg::WK_RST;
      else if (ce)
      begin
         if (soft_reset_req)
            wk_q <= wbc_pkg::WK_RST;
         else if (failsafe_entry)
            wk_q <= (wk_q & wbc_pkg::WK_FS_KEEP) | wbc_pkg::WK_FS_SET;
         else if (wr_ok && hit(frame, wbc_pkg::ADDR_WK))
            wk_q <= merge(wk_q, frame.data, wbc_pkg::WK_WMASK);
      end
   end

   // ****************************************
   // Derived outputs
   // ****************************************
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fo_q   <= 1'b0;
         wake_q <= 1'b0;
      end
      else if (ce)
      begin
         fo_q   <= hw_q[wbc_pkg::FAIL_OUT_SW_ENABLE_BIT] || failure_flag;
         wake_q <= bus_wake_in_stop && wd_q[wbc_pkg::WD_WAKE_BIT]
                   && (sbc_mode == wbc_pkg::MODE_STOP);
      end
   end

   assign failure_outputs     = fo_q;
   assign wdog_bus_wake_start = wake_q;
   assign wdog_cfg.off_in_stop  = wd_q[wbc_pkg::WD_STOP_BIT];
   assign wdog_cfg.window_sel   = wd_q[wbc_pkg::WDOG_WINDOW_SELECT_BIT];
   assign wdog_cfg.period_valid = (period_ms(wd_q[2:0]) != 10'h000);
   assign wdog_cfg.period_ms    = period_ms(wd_q[2:0]);

   // One register bit feeds every LIN transceiver alike
   genvar gi;
   generate
      for (gi = 0; gi < wbc_pkg::LIN_XCVRS; gi++)
      begin : g_lin
         assign lin_slope_bypass[gi]  = bus_q[wbc_pkg::LIN_FLASH_BIT];
         assign lin_low_slope[gi]     = bus_q[wbc_pkg::LIN_LOW_SLOPE_BIT];
         assign lin_tx_timeout_en[gi] = bus_q[wbc_pkg::LIN_TO_BIT];
      end
   endgenerate

   assign lin_mode_field          = bus_q[4:3];
   assign can_mode_field          = bus_q[1:0];
   assign peak_current_thresh_sel = peak_q[wbc_pkg::PEAK_BIT];
   assign aux_reg_voltage_cfg     = hw_q[7];
   assign aux_reg_load_share      = hw_q[3];

   // ****************************************
   // Assertions
   // ****************************************
   a_fail_flag_on: assert property (@(posedge clock) disable iff (rst)
      ce && failure_flag |=> failure_outputs)
      else $error("failure outputs off while failure flag set");

   a_fo_restart: assert property (@(posedge clock) disable iff (rst)
      ce && restart_entry ##1 ce |=> !failure_outputs || $past(failure_flag))
      else $error("failure outputs still on after restart");

   a_soft_keep: assert property (@(posedge clock) disable iff (rst)
      ce && soft_reset_req |=> hw_q == ($past(hw_q) & wbc_pkg::HW_SOFT_KEEP))
      else $error("soft reset altered kept bits");

   a_wd_restart: assert property (@(posedge clock) disable iff (rst)
      ce && restart_entry && !soft_reset_req |=>
         wd_q[2:0] == 3'h4 && !wd_q[6] && wd_q[5:4] == $past(wd_q[5:4]))
      else $error("watchdog restart value wrong");

   a_fs_values: assert property (@(posedge clock) disable iff (rst)
      ce && failsafe_entry && !soft_reset_req |=> bus_q[4:0] == 5'h09 && wk_q[2:0] == 3'h7)
      else $error("fail-safe values not loaded");

   a_peak_stop: assert property (@(posedge clock) disable iff (rst)
      ce && sbc_mode == wbc_pkg::MODE_STOP && !soft_reset_req |=> $stable(peak_q))
      else $error("peak bit changed in stop mode");

   a_resv_zero: assert property (@(posedge clock) disable iff (rst)
      !wd_q[3] && !bus_q[2] && peak_q[7:6] == 2'h0 && peak_q[4:0] == 5'h00 && !hw_q[2])
      else $error("reserved bit set");

   a_period_undef: assert property (@(posedge clock) disable iff (rst)
      wd_q[2:1] == 2'h3 |-> !wdog_cfg.period_valid && wdog_cfg.period_ms == 10'h000)
      else $error("undefined period code selects a period");

   a_wake_start: assert property (@(posedge clock) disable iff (rst)
      ce && bus_wake_in_stop && !wd_q[4] |=> !wdog_bus_wake_start)
      else $error("watchdog started with wake start disabled");

   a_lin_opts: assert property (@(posedge clock) disable iff (rst)
      ce && wr_ok && hit(frame, wbc_pkg::ADDR_BUS) |=>
         lin_slope_bypass == {wbc_pkg::LIN_XCVRS{$past(frame.data[wbc_pkg::LIN_FLASH_BIT])}}
         && lin_low_slope == {wbc_pkg::LIN_XCVRS{$past(frame.data[wbc_pkg::LIN_LOW_SLOPE_BIT])}}
         && lin_tx_timeout_en == {wbc_pkg::LIN_XCVRS{$past(frame.data[wbc_pkg::LIN_TO_BIT])}})
      else $error("LIN option write not applied");

   a_bus_modes: assert property (@(posedge clock) disable iff (rst)
      ce && wr_ok && hit(frame, wbc_pkg::ADDR_BUS) |=>
         lin_mode_field == $past(frame.data[4:3]) && can_mode_field == $past(frame.data[1:0]))
      else $error("transceiver mode write not applied");

   a_bus_restart: assert property (@(posedge clock) disable iff (rst)
      ce && restart_entry && !soft_reset_req && !failsafe_entry |=>
         !bus_q[wbc_pkg::BUS_RSV_BIT] && bus_q[7:5] == $past(bus_q[7:5])
         && {lin_mode_field, can_mode_field} == $past(restart_bus_modes))
      else $error("bus restart value wrong");

   a_wd_write: assert property (@(posedge clock) disable iff (rst)
      ce && wr_ok && hit(frame, wbc_pkg::ADDR_WD) |=>
         wdog_cfg.off_in_stop == $past(frame.data[wbc_pkg::WD_STOP_BIT])
         && wdog_cfg.window_sel == $past(frame.data[wbc_pkg::WDOG_WINDOW_SELECT_BIT]))
      else $error("watchdog type or stop bit not applied");

   a_sw_fail_out_sw_enable: assert property (@(posedge clock) disable iff (rst)
      ce && hw_q[wbc_pkg::FAIL_OUT_SW_ENABLE_BIT] |=> failure_outputs)
      else $error("software enable left failure outputs off");

   a_peak_write: assert property (@(posedge clock) disable iff (rst)
      ce && wr_ok && hit(frame, wbc_pkg::ADDR_PEAK) && peak_open |=>
         peak_current_thresh_sel == $past(frame.data[wbc_pkg::PEAK_BIT]))
      else $error("peak threshold write not applied");

   c_write_bus: cover property (@(posedge clock) disable iff (rst)
      frame_valid && hit(frame, wbc_pkg::ADDR_BUS));
   c_restart: cover property (@(posedge clock) disable iff (rst) ce && restart_entry);
   c_failsafe: cover property (@(posedge clock) disable iff (rst) ce && failsafe_entry);
   c_wake_start: cover property (@(posedge clock) disable iff (rst) wdog_bus_wake_start);

endmodule // wbc_regs

`default_nettype wire

// [sim/wbc_host.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host SPI master model
// ****************************************
module wbc_host (
   // Clock
   input  wire logic clock,
   // Serial pins
   output logic      chip_select_n,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo
);
   initial
   begin
      chip_select_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   // Phases of 5 or 8 clocks keep sclk well under the oversampling limit
   task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                       input logic slow, output logic [7:0] rd);
      logic [15:0] word;
      logic [15:0] got;
      int          ph;
      word = {d, w, a};
      if (w && a == wbc_pkg::ADDR_WD)
      begin
         word[15] = ^d[6:0];
      end
      ph = slow ? 8 : 5;
      hold(1);
      chip_select_n = 1'b0;
      hold(3);
      for (int i = 0; i < 16; i++)
      begin
         sdi = word[i];
         hold(ph);
         got[i] = sdo;
         sclk = 1'b1;
         hold(ph);
         sclk = 1'b0;
      end
      hold(ph);
      chip_select_n = 1'b1;
      // Released line must not keep showing the last bit
      sdi = ~sdi;
      hold(12);
      rd = got[15:8];
   endtask
endmodule // wbc_host

`default_nettype wire

// [sim/wbc_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module wbc_regs_tb;
   // ****************************************
   // Signals
   // ****************************************
   logic                   clock, rst, ce, chip_select_n, sclk, sdi, sdo, sdo_oe;
   wbc_pkg::wbc_mode_t     sbc_mode;
   logic                   soft_reset_req, restart_entry, failsafe_entry;
   logic                   failure_flag, bus_wake_in_stop;
   logic [3:0]             restart_bus_modes;
   wbc_pkg::wbc_wdog_cfg_t wdog_cfg;
   logic                   wdog_bus_wake_start, peak_current_thresh_sel;
   logic                   aux_reg_voltage_cfg, aux_reg_load_share, failure_outputs;
   logic [1:0]             lin_slope_bypass, lin_low_slope, lin_tx_timeout_en;
   logic [1:0]             lin_mode_field, can_mode_field;
   logic [31:0]            lfsr_q = 32'h7de8f0fa;
   logic [7:0]             d, e;
   int                     bad_count = 0;
   int                     n_compared = 0;
   int                     wake_cnt = 0;

   wbc_regs i_wbc_regs (.clock, .rst, .ce, .chip_select_n, .sclk, .sdi, .sdo, .sdo_oe,
      .sbc_mode, .soft_reset_req, .restart_entry, .restart_bus_modes, .failsafe_entry,
      .failure_flag, .bus_wake_in_stop, .wdog_cfg, .wdog_bus_wake_start,
      .lin_slope_bypass, .lin_low_slope, .lin_tx_timeout_en, .lin_mode_field,
      .can_mode_field, .peak_current_thresh_sel, .aux_reg_voltage_cfg,
      .aux_reg_load_share, .failure_outputs);

   wbc_host i_wbc_host (.clock, .chip_select_n, .sclk, .sdi, .sdo);

   // ****************************************
   // Helpers
   // ****************************************
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   always @(negedge clock)
   begin
      if (wdog_bus_wake_start === 1'b1) wake_cnt++;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask

   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[7:0];
   endfunction

   function automatic logic [9:0] exp_period(input logic [2:0] c);
      case (c)
         3'h0: return 10'd10;
         3'h1: return 10'd20;
         3'h2: return 10'd50;
         3'h3: return 10'd100;
         3'h4: return 10'd200;
         3'h5: return 10'd500;
         default: return 10'd0;
      endcase
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      logic [7:0] rd;
      i_wbc_host.xfer(a, 1'b1, v, v[2], rd);
   endtask

   // Readback lags one frame, so the second frame returns the value
   task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] rd;
      i_wbc_host.xfer(a, 1'b0, 8'h00, 1'b0, rd);
      i_wbc_host.xfer(a, 1'b0, 8'h00, 1'b1, rd);
      check(16'(rd), 16'(exp));
   endtask

   // k: 0 bus wake, 1 restart, 2 fail-safe, 3 soft reset
   task automatic pulse(input int k);
      tick(1);
      {soft_reset_req, failsafe_entry, restart_entry, bus_wake_in_stop} = 4'(1 << k);
      tick(1);
      {soft_reset_req, failsafe_entry, restart_entry, bus_wake_in_stop} = 4'h0;
      tick(4);
   endtask

   task automatic complete_run();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #(60000 * 25);
      bad_count++;
      $display("Error at %0t: run hung", $time);
      complete_run();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      sbc_mode = wbc_pkg::MODE_NORMAL;
      {soft_reset_req, failsafe_entry, restart_entry, bus_wake_in_stop} = 4'h0;
      failure_flag = 1'b0;
      restart_bus_modes = 4'h0;
      repeat (4) @(posedge clock);
      #2 rst = 1'b0;
      tick(3);
      chk_reg(wbc_pkg::ADDR_WD, 8'h14);
      chk_reg(wbc_pkg::ADDR_BUS, 8'h20);
      chk_reg(wbc_pkg::ADDR_PEAK, 8'h00);
      check(16'(lin_tx_timeout_en), 16'h3);
      check(16'(sdo_oe), 16'h0);
      for (int i = 0; i < 8; i++)
      begin
         d = rnd();
         d[4:3] = i[1:0];
         d[1:0] = ~i[1:0];
         wr(wbc_pkg::ADDR_BUS, d);
         check(16'({lin_slope_bypass, lin_low_slope, lin_tx_timeout_en}),
               16'({{2{d[7]}}, {2{d[6]}}, {2{d[5]}}}));
         check(16'({lin_mode_field, can_mode_field}), 16'({d[4:3], d[1:0]}));
         chk_reg(wbc_pkg::ADDR_BUS, d & 8'hfb);
      end
      for (int i = 0; i < 8; i++)
      begin
         d = rnd();
         d[2:0] = i[2:0];
         wr(wbc_pkg::ADDR_WD, d);
         e = {^d[6:0], d[6:0]} & 8'hf7;
         check(16'(wdog_cfg.period_ms), 16'(exp_period(d[2:0])));
         check(16'({wdog_cfg.period_valid, wdog_cfg.window_sel, wdog_cfg.off_in_stop}),
               16'({i < 6, d[5], d[6]}));
         chk_reg(wbc_pkg::ADDR_WD, e);
      end
      sbc_mode = wbc_pkg::MODE_STOP;
      wr(wbc_pkg::ADDR_WD, 8'h14);
      pulse(0);
      check(16'(wake_cnt), 16'h1);
      wr(wbc_pkg::ADDR_WD, 8'h04);
      pulse(0);
      check(16'(wake_cnt), 16'h1);
      wr(wbc_pkg::ADDR_PEAK, 8'h00);
      sbc_mode = wbc_pkg::MODE_NORMAL;
      wr(wbc_pkg::ADDR_PEAK, 8'hff);
      check(16'(peak_current_thresh_sel), 16'h1);
      chk_reg(wbc_pkg::ADDR_PEAK, 8'h20);
      sbc_mode = wbc_pkg::MODE_STOP;
      wr(wbc_pkg::ADDR_PEAK, 8'h00);
      chk_reg(wbc_pkg::ADDR_PEAK, 8'h20);
      sbc_mode = wbc_pkg::MODE_INIT;
      wr(wbc_pkg::ADDR_PEAK, 8'h00);
      check(16'(peak_current_thresh_sel), 16'h0);
      sbc_mode = wbc_pkg::MODE_NORMAL;
      wr(wbc_pkg::ADDR_HW, 8'h20);
      check(16'(failure_outputs), 16'h1);
      failure_flag = 1'b1;
      wr(wbc_pkg::ADDR_HW, 8'h00);
      check(16'(failure_outputs), 16'h1);
      failure_flag = 1'b0;
      tick(3);
      check(16'(failure_outputs), 16'h0);
      // Restart with software enable set and every writable watchdog and bus bit up
      wr(wbc_pkg::ADDR_HW, 8'h20);
      wr(wbc_pkg::ADDR_WD, 8'hff);
      wr(wbc_pkg::ADDR_BUS, 8'hff);
      restart_bus_modes = 4'b1001;
      pulse(1);
      check(16'(failure_outputs), 16'h0);
      check(16'({lin_mode_field, can_mode_field}), 16'h9);
      chk_reg(wbc_pkg::ADDR_HW, 8'h00);
      chk_reg(wbc_pkg::ADDR_WD, 8'hb4);
      chk_reg(wbc_pkg::ADDR_BUS, 8'hf1);
      wr(wbc_pkg::ADDR_WK, 8'ha0);
      pulse(2);
      chk_reg(wbc_pkg::ADDR_BUS, 8'he9);
      chk_reg(wbc_pkg::ADDR_WK, 8'ha7);
      // Frozen clock enable must swallow a soft reset
      ce = 1'b0;
      pulse(3);
      ce = 1'b1;
      check(16'({lin_mode_field, can_mode_field}), 16'h5);
      wr(7'h7f, 8'hff);
      chk_reg(wbc_pkg::ADDR_BUS, 8'he9);
      wr(wbc_pkg::ADDR_HW, 8'hff);
      pulse(3);
      check(16'({aux_reg_voltage_cfg, aux_reg_load_share}), 16'h3);
      chk_reg(wbc_pkg::ADDR_HW, 8'hc9);
      chk_reg(wbc_pkg::ADDR_WD, 8'h14);
      chk_reg(wbc_pkg::ADDR_BUS, 8'h20);
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(3);
      chk_reg(wbc_pkg::ADDR_HW, 8'h00);
      complete_run();
   end
endmodule // wbc_regs_tb

`default_nettype wire
